// *** hw/txrxm_defines.vh ***
// register map, field positions and encodings for the mode configuration bank
`ifndef TXRXM_DEFINES_VH
`define TXRXM_DEFINES_VH
`define TXRXM_IDX_TX_MODE 8'h12
`define TXRXM_IDX_RX_MODE 8'h13
`define TXRXM_IDX_CTRL 8'h20
`define TXRXM_IDX_STATUS 8'h21
`define TXRXM_TX_MODE_RESET 8'h00
`define TXRXM_RX_MODE_RESET 8'h00
`define TXRXM_BIT_CRC 7
`define TXRXM_SPD_HI 6
`define TXRXM_SPD_LO 4
`define TXRXM_BIT_INV 3
`define TXRXM_BIT_MIX 2
`define TXRXM_BIT_NOERR 3
`define TXRXM_BIT_MULTI 2
`define TXRXM_FRM_HI 1
`define TXRXM_FRM_LO 0
`define TXRXM_SPD_106 3'h0
`define TXRXM_SPD_212 3'h1
`define TXRXM_SPD_424 3'h2
`define TXRXM_SPD_848 3'h3
`define TXRXM_SPD_1696 3'h4
`define TXRXM_SPD_3392 3'h5
`define TXRXM_FRM_TYPEA 2'h0
`define TXRXM_FRM_ACTIVE 2'h1
`define TXRXM_FRM_PASSIVE 2'h2
`define TXRXM_FRM_TYPEB 2'h3
`define TXRXM_MIN_BITS 4'h4
`define TXRXM_PRESET_0000 2'h0
`define TXRXM_PRESET_6363 2'h1
`define TXRXM_PRESET_A671 2'h2
`define TXRXM_PRESET_FFFF 2'h3
`define TXRXM_CMD_RECEIVE 4'h8
`endif

// *** hw/txrxm_mode_config.v ***
// mode configuration registers and receive sequencing for the framing unit
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "txrxm_defines.vh"

// Functional notes
// - transmit checksum enable bit 7 makes the coder append a checksum
// - receive checksum enable makes the decoder check each received frame
// - speed codes 000..101 select 106..3392 kbit, 110 and 111 reserved
// - rates above 424 kbit use active mode 424 kbit bit coding
// - analog path limited to 424 kbit, digital coder handles all rates
// - modulation invert bit 3 inverts transmitted modulation
// - envelope mix bit 2 combines envelope pin with coder output
// - transmit framing: 00 A, 01 active, 10 passive 212/424, 11 B
// - receive framing uses the same encoding as transmit
// - ignore-invalid discards streams under 4 bits, receiver stays on
// - for Type B ignoring also needs start-of-frame required
// - multi-frame off: receiver stops after one frame
// - multi-frame on: receive commands do not end by themselves
// - multi-frame: error register copy appended to fifo after each stream that is not discarded
// - checksum preset chosen from mode settings during communication
module txrxm_mode_config #(
    parameter ERR_W = 8
) (
    input wire core_clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire envelope_input_pin,
    input wire coder_out,
    input wire rx_start,
    input wire rx_bit,
    input wire rx_end,
    input wire start_of_frame_required,
    input wire [ERR_W-1:0] error_register,
    input wire [3:0] command_register,
    input wire command_write,
    output reg tx_modulation,
    output reg tx_checksum_append,
    output reg rx_checksum_check,
    output reg [2:0] tx_bit_rate_out,
    output reg [2:0] rx_bit_rate_out,
    output reg [1:0] tx_frame_scheme_out,
    output reg [1:0] rx_frame_scheme_out,
    output reg tx_use_active424_coding,
    output reg rx_use_active424_coding,
    output reg analog_rate_ok,
    output reg [1:0] checksum_preset_select,
    output reg rx_active,
    output reg frame_done,
    output reg stream_discard,
    output reg fifo_push,
    output reg [ERR_W-1:0] fifo_data
);

////////////////////////////////////////////////////////////////////////////////
function above_424;
    input [2:0] spd;
    begin
        above_424 = (spd == `TXRXM_SPD_848) || (spd == `TXRXM_SPD_1696) ||
            (spd == `TXRXM_SPD_3392);
    end
endfunction

function analog_ok;
    input [2:0] spd;
    begin
        analog_ok = (spd == `TXRXM_SPD_106) || (spd == `TXRXM_SPD_212) ||
            (spd == `TXRXM_SPD_424);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg [7:0] transmit_mode_config_reg;
reg [7:0] receive_mode_config_reg;
reg rx_enable_reg;
reg rx_active_reg;
reg [3:0] bit_count_reg;
reg env_s1_reg;
reg env_s2_reg;

wire [7:0] word_idx = paddr[9:2];
wire setup = psel && !penable;
wire access = psel && penable;
wire wr_tx = access && pwrite && (word_idx == `TXRXM_IDX_TX_MODE);
wire wr_rx = access && pwrite && (word_idx == `TXRXM_IDX_RX_MODE);
wire wr_ctrl = access && pwrite && (word_idx == `TXRXM_IDX_CTRL);
wire mapped = (word_idx == `TXRXM_IDX_TX_MODE) || (word_idx == `TXRXM_IDX_RX_MODE) ||
    (word_idx == `TXRXM_IDX_CTRL) || (word_idx == `TXRXM_IDX_STATUS);
wire misaligned = (paddr[1:0] != 2'h0) || (paddr[31:10] != 22'h0);

wire [2:0] tx_spd = transmit_mode_config_reg[`TXRXM_SPD_HI:`TXRXM_SPD_LO];
wire [2:0] rx_spd = receive_mode_config_reg[`TXRXM_SPD_HI:`TXRXM_SPD_LO];
wire [1:0] tx_frm = transmit_mode_config_reg[`TXRXM_FRM_HI:`TXRXM_FRM_LO];
wire [1:0] rx_frm = receive_mode_config_reg[`TXRXM_FRM_HI:`TXRXM_FRM_LO];
wire multi = receive_mode_config_reg[`TXRXM_BIT_MULTI];
wire noerr = receive_mode_config_reg[`TXRXM_BIT_NOERR];

wire ignore_ok = noerr && ((rx_frm != `TXRXM_FRM_TYPEB) || start_of_frame_required);
wire short_stream = bit_count_reg < `TXRXM_MIN_BITS;
wire end_evt = rx_active_reg && rx_end;
wire discard = end_evt && short_stream && ignore_ok;
wire good_end = end_evt && !discard;
// leaving receive: other command written, or multi bit cleared while multi-frame
wire cmd_stop = command_write && (command_register != `TXRXM_CMD_RECEIVE);
wire multi_clear = wr_rx && !pwdata[`TXRXM_BIT_MULTI] && multi;

////////////////////////////////////////////////////////////////////////////////
// register bank over apb, zero wait state
always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        transmit_mode_config_reg <= `TXRXM_TX_MODE_RESET;
        receive_mode_config_reg <= `TXRXM_RX_MODE_RESET;
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= setup;
        pslverr <= setup && (misaligned || !mapped);
        if (wr_tx && !misaligned) begin
            transmit_mode_config_reg <= pwdata[7:0];
        end
        if (wr_rx && !misaligned) begin
            receive_mode_config_reg <= pwdata[7:0];
        end
        if (setup && !pwrite) begin
            if (misaligned) begin
                prdata <= 32'h0;
            end else begin
                case (word_idx)
                    `TXRXM_IDX_TX_MODE: prdata <= {24'h0, transmit_mode_config_reg};
                    `TXRXM_IDX_RX_MODE: prdata <= {24'h0, receive_mode_config_reg};
                    `TXRXM_IDX_CTRL: prdata <= {31'h0, rx_enable_reg};
                    `TXRXM_IDX_STATUS: prdata <= {27'h0, bit_count_reg, rx_active_reg};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// receive sequencing
always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        rx_enable_reg <= 1'b0;
        rx_active_reg <= 1'b0;
        bit_count_reg <= 4'h0;
        rx_active <= 1'b0;
        frame_done <= 1'b0;
        stream_discard <= 1'b0;
        fifo_push <= 1'b0;
        fifo_data <= {ERR_W{1'b0}};
    end else begin
        frame_done <= good_end;
        stream_discard <= discard;
        fifo_push <= good_end && multi;
        if (good_end && multi) begin
            fifo_data <= error_register;
        end
        if (wr_ctrl && !misaligned) begin
            rx_enable_reg <= pwdata[0];
        end else if (cmd_stop || multi_clear) begin
            rx_enable_reg <= 1'b0;
        end else if (good_end && !multi) begin
            rx_enable_reg <= 1'b0;
        end
        if (!rx_enable_reg || cmd_stop) begin
            rx_active_reg <= 1'b0;
            bit_count_reg <= 4'h0;
        end else if (end_evt) begin
            // discard keeps listening; multi keeps accepting frames
            rx_active_reg <= discard || multi;
            bit_count_reg <= 4'h0;
        end else if (rx_start) begin
            rx_active_reg <= 1'b1;
            bit_count_reg <= 4'h0;
        end else if (rx_active_reg && rx_bit && (bit_count_reg != 4'hf)) begin
            bit_count_reg <= bit_count_reg + 4'h1;
        end
        rx_active <= rx_active_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// coder controls
always @(posedge core_clk or posedge reset) begin
    if (reset) begin
        env_s1_reg <= 1'b0;
        env_s2_reg <= 1'b0;
        tx_modulation <= 1'b0;
        tx_checksum_append <= 1'b0;
        rx_checksum_check <= 1'b0;
        tx_bit_rate_out <= `TXRXM_SPD_106;
        rx_bit_rate_out <= `TXRXM_SPD_106;
        tx_frame_scheme_out <= `TXRXM_FRM_TYPEA;
        rx_frame_scheme_out <= `TXRXM_FRM_TYPEA;
        tx_use_active424_coding <= 1'b0;
        rx_use_active424_coding <= 1'b0;
        analog_rate_ok <= 1'b0;
        checksum_preset_select <= `TXRXM_PRESET_0000;
    end else begin
        env_s1_reg <= envelope_input_pin;
        env_s2_reg <= env_s1_reg;
        tx_modulation <= (transmit_mode_config_reg[`TXRXM_BIT_MIX] ?
            (coder_out & env_s2_reg) : coder_out) ^
            transmit_mode_config_reg[`TXRXM_BIT_INV];
        tx_checksum_append <= transmit_mode_config_reg[`TXRXM_BIT_CRC];
        rx_checksum_check <= receive_mode_config_reg[`TXRXM_BIT_CRC];
        tx_bit_rate_out <= tx_spd;
        rx_bit_rate_out <= rx_spd;
        tx_frame_scheme_out <= tx_frm;
        rx_frame_scheme_out <= rx_frm;
        tx_use_active424_coding <= above_424(tx_spd);
        rx_use_active424_coding <= above_424(rx_spd);
        analog_rate_ok <= analog_ok(tx_spd) && analog_ok(rx_spd);
        case (tx_frm)
            `TXRXM_FRM_TYPEA: checksum_preset_select <= `TXRXM_PRESET_6363;
            `TXRXM_FRM_TYPEB: checksum_preset_select <= `TXRXM_PRESET_FFFF;
            default: checksum_preset_select <= `TXRXM_PRESET_0000;
        endcase
    end
end

endmodule // txrxm_mode_config

// *** test/txrxm_mode_config_assertions.sv ***
// port-level checks of the mode configuration bank
`timescale 1ns/1ps
module txrxm_mode_config_assertions #(parameter ERR_W = 8) (
    input wire core_clk, input wire reset, input wire psel, input wire penable,
    input wire pwrite, input wire [31:0] paddr, input wire [31:0] pwdata,
    input wire pready, input wire pslverr, input wire [ERR_W-1:0] error_register,
    input wire tx_checksum_append, input wire [2:0] tx_bit_rate_out,
    input wire [2:0] rx_bit_rate_out, input wire [1:0] tx_frame_scheme_out,
    input wire tx_use_active424_coding, input wire analog_rate_ok,
    input wire [1:0] checksum_preset_select, input wire rx_active, input wire frame_done,
    input wire stream_discard, input wire fifo_push, input wire [ERR_W-1:0] fifo_data
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_apb_ready: assert property (psel && !penable |=> pready) else $error("no ready");
    a_bad_addr: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access accepted");
    a_crc_copy: assert property (psel && penable && pready && pwrite && paddr == 32'h48
        |-> ##2 tx_checksum_append == $past(pwdata[7], 2)) else $error("crc enable wrong");
    a_fast_code: assert property (tx_use_active424_coding == (tx_bit_rate_out > 3'h2))
        else $error("fast coding wrong");
    a_analog_lim: assert property (!$past(reset) |-> analog_rate_ok ==
        (tx_bit_rate_out <= 3'h2 && rx_bit_rate_out <= 3'h2)) else $error("analog flag wrong");
    a_preset_map: assert property (!$past(reset) |-> checksum_preset_select ==
        (tx_frame_scheme_out == 2'h0 ? 2'h1 : tx_frame_scheme_out == 2'h3 ? 2'h3 : 2'h0))
        else $error("preset wrong");
    a_push_data: assert property (fifo_push |-> frame_done && fifo_data == $past(error_register))
        else $error("error copy wrong");
    a_discard_on: assert property (stream_discard |-> !frame_done ##1 rx_active)
        else $error("discard ended reception");
    a_single_stop: assert property (frame_done && !fifo_push |-> ##[1:3] !rx_active)
        else $error("receiver not stopped");
    a_multi_stay: assert property (fifo_push |=> rx_active [*2])
        else $error("multi receive ended");
endmodule // txrxm_mode_config_assertions
bind txrxm_mode_config txrxm_mode_config_assertions #(.ERR_W(ERR_W)) u_chk (.*);

// *** test/txrxm_mode_config_tb.sv ***
// self-checking bench for the mode configuration bank
`timescale 1ns/1ps
module txrxm_mode_config_tb;
    reg core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, go = 0;
    reg [31:0] paddr = 0, pwdata = 0, rd;
    reg envelope_input_pin = 1, coder_out = 0, start_of_frame_required = 0, command_write = 0, er;
    reg [3:0] command_register = 0, nbits = 0;
    reg [7:0] error_register = 8'h5a, v;
    wire [31:0] prdata;
    wire [7:0] fifo_data;
    wire [2:0] tx_bit_rate_out, rx_bit_rate_out;
    wire [1:0] tx_frame_scheme_out, rx_frame_scheme_out;
    wire pready, pslverr, tx_modulation, tx_checksum_append, rx_checksum_check, analog_rate_ok;
    wire tx_use_active424_coding, rx_active, frame_done, stream_discard, fifo_push, busy;
    wire rx_start, rx_bit, rx_end, rx_use_active424_coding;
    wire [1:0] checksum_preset_select;
    integer mismatches = 0, num_checks = 0, n_done = 0, n_disc = 0, n_push = 0, i;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        n_done <= n_done + frame_done;
        n_disc <= n_disc + stream_discard;
        n_push <= n_push + fifo_push;
    end
    txrxm_peer peer (.core_clk, .go, .nbits, .rx_start, .rx_bit, .rx_end, .busy);
    txrxm_mode_config #(.ERR_W(8)) dut (.core_clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .envelope_input_pin, .coder_out, .rx_start,
        .rx_bit, .rx_end, .start_of_frame_required, .error_register, .command_register,
        .command_write, .tx_modulation, .tx_checksum_append, .rx_checksum_check,
        .tx_bit_rate_out, .rx_bit_rate_out, .tx_frame_scheme_out, .rx_frame_scheme_out,
        .tx_use_active424_coding, .rx_use_active424_coding, .analog_rate_ok,
        .checksum_preset_select, .rx_active, .frame_done, .stream_discard, .fifo_push,
        .fifo_data);
    task conclude;
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            num_checks++;
            if (g !== e) begin
                mismatches++;
                $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task tmo(input integer k);
        if (k > 40) begin mismatches++; conclude; end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge core_clk);
    endtask
    task apb(input w, input [31:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge core_clk);
            psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge core_clk);
            penable <= 1;
            k = 0;
            @(posedge core_clk);
            while (pready !== 1'b1) begin k++; tmo(k); @(posedge core_clk); end
            rd = prdata; er = pslverr;
            psel <= 0; penable <= 0;
        end
    endtask
    task frame(input [3:0] n);
        integer k;
        begin
            @(posedge core_clk); nbits <= n; go <= 1;
            @(posedge core_clk); go <= 0;
            k = 0;
            do begin @(negedge core_clk); k++; tmo(k); end while (busy);
            cyc(4);
        end
    endtask
    task t_regs;
        begin
            apb(0, 32'h48, 0); chk("tx_mode", 0, rd);
            apb(0, 32'h4c, 0); chk("rx_mode", 0, rd);
            apb(1, 32'h3c, 32'hff); chk("slverr", 1, er);
            apb(0, 32'h3c, 0); chk("unmapped", 0, rd);
        end
    endtask
    task t_rates;
        for (i = 0; i < 6; i++) begin
            v = {i != 0, i[2:0], 2'h0, i[1:0]};
            apb(1, 32'h48, 32'hab00_0000 | v); apb(1, 32'h4c, v);
            apb(0, 32'h48, 0); chk("tx_readback", v, rd);
            cyc(2);
            chk("tx_rate", i, tx_bit_rate_out);
            chk("rx_rate", i, rx_bit_rate_out);
            chk("tx_frame", i % 4, tx_frame_scheme_out);
            chk("rx_frame", i % 4, rx_frame_scheme_out);
            chk("tx_crc", i != 0, tx_checksum_append);
            chk("rx_crc", i != 0, rx_checksum_check);
            chk("fast", i > 2, tx_use_active424_coding);
            chk("rx_fast", i > 2, rx_use_active424_coding);
            chk("preset", (i % 4 == 0) ? 1 : (i % 4 == 3) ? 3 : 0, checksum_preset_select);
            chk("analog", i < 3, analog_rate_ok);
        end
    endtask
    task t_mod;
        for (i = 0; i < 16; i++) begin
            apb(1, 32'h48, {i[3:2], 2'h0});
            @(posedge core_clk); coder_out <= i[1]; envelope_input_pin <= i[0];
            cyc(5);
            chk("modulation", (i[2] ? i[1] & i[0] : i[1]) ^ i[3], tx_modulation);
        end
    endtask
    task t_rx;
        begin
            apb(1, 32'h4c, 32'h08); apb(1, 32'h80, 1); cyc(3);
            frame(2); chk("discard", 1, n_disc); chk("active", 1, rx_active);
            frame(8); chk("done", 1, n_done); chk("active", 0, rx_active);
            apb(1, 32'h4c, 32'h0b); apb(1, 32'h80, 1); cyc(3);
            frame(2); chk("b_done", 2, n_done); chk("b_active", 0, rx_active);
            @(posedge core_clk); start_of_frame_required <= 1;
            apb(1, 32'h80, 1); cyc(3);
            frame(2); chk("b_discard", 2, n_disc);
            apb(1, 32'h4c, 32'h04); apb(1, 32'h80, 1); cyc(3);
            frame(8); frame(5); chk("pushes", 2, n_push);
            chk("err_copy", 8'h5a, fifo_data); chk("m_active", 1, rx_active);
            @(posedge core_clk); command_register <= 4'h0; command_write <= 1;
            @(posedge core_clk); command_write <= 0;
            cyc(3); chk("stopped", 0, rx_active);
        end
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 0;
        t_regs; t_rates; t_mod; t_rx;
        conclude;
    end
endmodule // txrxm_mode_config_tb

// *** test/txrxm_peer.sv ***
// decoder-side model: start, bit and end pulses for one received stream
`timescale 1ns/1ps
module txrxm_peer (
    input wire core_clk,
    input wire go,
    input wire [3:0] nbits,
    output reg rx_start = 0,
    output reg rx_bit = 0,
    output reg rx_end = 0,
    output reg busy = 0
);
    reg [4:0] left = 0;
    always @(posedge core_clk) begin
        rx_start <= go && !busy;
        rx_bit <= busy && left > 5'h1;
        rx_end <= busy && left == 5'h1;
        if (go && !busy) begin
            busy <= 1'b1;
            left <= {1'b0, nbits} + 5'h1;
        end else if (busy) begin
            left <= left - 5'h1;
            busy <= left != 5'h1;
        end
    end
endmodule // txrxm_peer
